// File: core_pkg.sv
/*
 Shared constants and types for the 8-bit core: phase encoding, register
 file offsets, status bit positions, reset values and instruction encodings.
 Assumes a single 250 MHz core clock and a 12-bit instruction word.
*/
package core_pkg;

   // One-hot phase of the instruction cycle.
   typedef enum logic [3:0] {
      PH_ONE = 4'h1,
      PH_TWO = 4'h2,
      PH_THREE = 4'h4,
      PH_FOUR = 4'h8
   } phase_t;

   // Restart request and its cause; any set bit restarts the core.
   typedef struct packed {
      logic por;
      logic ext_pin;
      logic watchdog;
      logic wake;
   } restart_t;

   // File register offsets.
   localparam logic [4:0] ADDR_INDIRECT = 5'h00;
   localparam logic [4:0] ADDR_TIMER0 = 5'h01;
   localparam logic [4:0] ADDR_PC_LOW = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_POINTER = 5'h04;
   localparam logic [4:0] ADDR_OSC_TRIM = 5'h05;
   localparam logic [4:0] ADDR_PORT = 5'h06;
   localparam logic [4:0] ADDR_COMPARATOR = 5'h07;
   localparam logic [4:0] GPR_BASE_LARGE = 5'h08;
   localparam logic [4:0] GPR_BASE_SMALL = 5'h10;
   localparam int GPR_DEPTH = 24;

   // Status bit positions.
   localparam int ST_CARRY = 0;
   localparam int ST_DIGIT = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_POWERDOWN = 3;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_PIN_WAKE = 7;

   // Reset values.
   localparam logic [9:0] PC_RESET = 10'h3ff;
   localparam logic [7:0] STATUS_POR = 8'h18;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] OSC_TRIM_RESET = 8'hfe;
   localparam logic [7:0] COMPARATOR_RESET = 8'hff;
   localparam logic [3:0] PORT_DIR_RESET = 4'hf;
   localparam logic [2:0] POINTER_HIGH = 3'h7;

   // Program counter and implemented-depth masks per variant.
   localparam logic [9:0] PC_MASK_SMALL = 10'h1ff;
   localparam logic [9:0] PC_MASK_LARGE = 10'h3ff;
   localparam logic [9:0] DEPTH_MASK_SMALL = 10'h0ff;
   localparam logic [9:0] DEPTH_MASK_LARGE = 10'h1ff;

   // Instruction encodings.
   localparam logic [11:0] OPC_NOP = 12'h000;
   localparam logic [11:0] OPC_OPTION = 12'h002;
   localparam logic [11:0] OPC_TRIS_PORT = 12'h006;
   localparam logic [6:0] OPC_MOVE_ACC_TO_FILE = 7'h01;
   localparam logic [6:0] OPC_CLEAR_ACC = 7'h02;
   localparam logic [6:0] OPC_FILE_CLEAR = 7'h03;
   localparam logic [5:0] OPC_SUB = 6'h02;
   localparam logic [5:0] OPC_IOR = 6'h04;
   localparam logic [5:0] OPC_AND = 6'h05;
   localparam logic [5:0] OPC_ADD = 6'h07;
   localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
   localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
   localparam logic [3:0] OPC_BIT_SET = 4'h5;
   localparam logic [3:0] OPC_MOVE_LITERAL = 4'hc;
   localparam logic [2:0] OPC_JUMP = 3'h5;

   // Complete state of the core.
   typedef struct packed {
      logic [9:0] pc;
      logic [9:0] prog_addr;
      logic [11:0] instruction_latch;
      logic [7:0] acc;
      logic [7:0] operand;
      logic [7:0] status;
      logic [4:0] pointer;
      logic [7:0] timer0;
      logic [7:0] osc_trim;
      logic [7:0] comparator;
      logic [3:0] port_latch;
      logic [3:0] port_dir;
      logic [3:0] port_oe;
      logic [7:0] option;
      logic [3:0] pin_meta;
      logic [3:0] pin_sync;
      logic [GPR_DEPTH-1:0][7:0] general_purpose_register;
   } core_state_t;

endpackage

// File: core_timing.sv
/*
 Phase generator and restart combiner for the core.
 Assumes watchdog and wake requests come from logic on sys_clk; the external
 reset pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module core_timing (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ext_reset_pin_n,
   input wire logic watchdog_expired,
   input wire logic pin_change_wake,
   output core_pkg::phase_t phase,
   output core_pkg::restart_t restart
);

   typedef struct packed {
      logic pin_meta;
      logic pin_sync;
      logic por_pending;
      core_pkg::phase_t phase;
      core_pkg::restart_t restart;
   } timing_state_t;

   timing_state_t s_ff;
   timing_state_t nxt_s;

   // Clock divided by four into one-hot phases; restarts hold phase four, so phase one follows.
   always_comb begin
      nxt_s = s_ff;
      nxt_s.pin_meta = ext_reset_pin_n;
      nxt_s.pin_sync = s_ff.pin_meta;
      nxt_s.por_pending = 1'b0;
      nxt_s.restart.por = s_ff.por_pending;
      nxt_s.restart.ext_pin = ~s_ff.pin_sync;
      nxt_s.restart.watchdog = watchdog_expired;
      nxt_s.restart.wake = pin_change_wake;
      if (nxt_s.restart != '0) begin
         nxt_s.phase = core_pkg::PH_FOUR;
      end else begin
         nxt_s.phase = core_pkg::phase_t'({s_ff.phase[2:0], s_ff.phase[3]});
      end
   end

   // State register; power-on reset leaves one pending power-up restart.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_ff <= '{pin_meta: 1'b1, pin_sync: 1'b1, por_pending: 1'b1,
                   phase: core_pkg::PH_FOUR, restart: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign phase = s_ff.phase;
   assign restart = s_ff.restart;

endmodule // core_timing

`default_nettype wire

// File: core_fetch_regfile.sv
/*
 Fetch and execute pipeline with program counter, accumulator and register
 file of a small 8-bit core with 12-bit instructions.
 Assumes program memory outside answers prog_addr with prog_data on sys_clk
 before the fourth phase; port pins are asynchronous.
*/
// Notes on behaviour
// - Clock divided by four into four one-hot phases forming an instruction cycle.
// - Counter advances in phase one; fetched word latched in phase four.
// - Next word is fetched while the previous one executes.
// - Any counter change takes two cycles; the prefetched word is dropped.
// - Operand is read in phase two, destination written in phase four.
// - Small variant has a 9-bit counter over 512 words.
// - Small variant fetch addresses wrap into the first 256 words.
// - Large variant has a 10-bit counter over 1024 words.
// - Large variant fetch addresses wrap into the first 512 words.
// - After any reset fetching effectively starts at address zero.
// - Small variant has seven special and sixteen general registers.
// - Large variant has eight special and twenty-four general registers.
// - Address zero reaches the register that the pointer names.
// - Only the low counter byte is a file register; it resets to ones.
// - Flag-updating writes to status ignore written zero; add, subtract and file clear also ignore written digit and carry.
// - Time-out and power-down flags cannot be written.
// - Clearing status zeroes its upper three bits and sets zero.
// - Power-up, reset pin, watchdog and pin-change wake all restart the core.
// - An 8-bit accumulator without a file address holds operands and results.
// - In subtraction carry and digit carry are inverted borrows.
// - A dedicated instruction copies the accumulator into the config register.
`timescale 1ns/1ps
`default_nettype none

module core_fetch_regfile #(
   parameter bit large_variant = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ext_reset_pin_n,
   input wire logic watchdog_expired,
   input wire logic pin_change_wake,
   input wire logic [11:0] prog_data,
   input wire logic [3:0] port_pin_in,
   output logic [9:0] prog_addr,
   output logic [3:0] port_pin_out,
   output logic [3:0] port_pin_oe,
   output logic [7:0] option_cfg,
   output logic [7:0] acc_value,
   output core_pkg::phase_t phase
);

   core_pkg::core_state_t s_ff;
   core_pkg::core_state_t nxt_s;
   core_pkg::restart_t restart;

   logic [9:0] pc_mask;
   logic [9:0] depth_mask;
   logic [4:0] gpr_base;
   logic [4:0] eff_addr;
   logic [4:0] gpr_index;
   logic gpr_valid;
   logic [9:0] pc_next;
   logic [7:0] res;
   logic [8:0] sum;
   logic [4:0] nibble_sum;
   logic wr_file;
   logic wr_acc;
   logic upd_zero;
   logic upd_arith;
   logic jump;
   logic [9:0] jump_target;

   // Phase generator and restart combiner.
   core_timing u_core_timing (
      .sys_clk(sys_clk),
      .rst(rst),
      .ext_reset_pin_n(ext_reset_pin_n),
      .watchdog_expired(watchdog_expired),
      .pin_change_wake(pin_change_wake),
      .phase(phase),
      .restart(restart)
   );

   // Variant selection of counter width, implemented depth and register count.
   assign pc_mask = large_variant ? core_pkg::PC_MASK_LARGE : core_pkg::PC_MASK_SMALL;
   assign depth_mask = large_variant ? core_pkg::DEPTH_MASK_LARGE
                                     : core_pkg::DEPTH_MASK_SMALL;
   assign gpr_base = large_variant ? core_pkg::GPR_BASE_LARGE : core_pkg::GPR_BASE_SMALL;

   // Address zero is replaced by the pointer contents.
   assign eff_addr = (s_ff.instruction_latch[4:0] == core_pkg::ADDR_INDIRECT) ?
                     s_ff.pointer : s_ff.instruction_latch[4:0];
   assign gpr_index = eff_addr - core_pkg::GPR_BASE_LARGE;
   assign gpr_valid = (eff_addr >= gpr_base);
   assign pc_next = (s_ff.pc + 10'h001) & pc_mask;

   // Reads one file register; unimplemented addresses read zero.
   function automatic logic [7:0] file_read(input core_pkg::core_state_t st,
                                            input logic [4:0] a,
                                            input logic [4:0] idx,
                                            input logic valid);
      logic [7:0] v;
      v = 8'h00;
      if (a == core_pkg::ADDR_INDIRECT) begin
         v = 8'h00;
      end else if (a == core_pkg::ADDR_TIMER0) begin
         v = st.timer0;
      end else if (a == core_pkg::ADDR_PC_LOW) begin
         v = st.pc[7:0];
      end else if (a == core_pkg::ADDR_STATUS) begin
         v = st.status;
      end else if (a == core_pkg::ADDR_POINTER) begin
         v = {core_pkg::POINTER_HIGH, st.pointer};
      end else if (a == core_pkg::ADDR_OSC_TRIM) begin
         v = st.osc_trim;
      end else if (a == core_pkg::ADDR_PORT) begin
         v = {4'h0, st.pin_sync};
      end else if (a == core_pkg::ADDR_COMPARATOR) begin
         v = large_variant ? st.comparator : 8'h00;
      end else if (valid) begin
         v = st.general_purpose_register[idx];
      end
      return v;
   endfunction

   // Decode of the instruction in the execute slot, done in phase four.
   always_comb begin
      res = 8'h00;
      sum = 9'h000;
      nibble_sum = 5'h00;
      wr_file = 1'b0;
      wr_acc = 1'b0;
      upd_zero = 1'b0;
      upd_arith = 1'b0;
      jump = 1'b0;
      jump_target = {1'b0, s_ff.instruction_latch[8:0]} & pc_mask;
      if (s_ff.instruction_latch[11:9] == core_pkg::OPC_JUMP) begin
         jump = 1'b1;
      end else if (s_ff.instruction_latch[11:8] == core_pkg::OPC_MOVE_LITERAL) begin
         res = s_ff.instruction_latch[7:0];
         wr_acc = 1'b1;
      end else if (s_ff.instruction_latch[11:8] == core_pkg::OPC_BIT_CLEAR) begin
         res = s_ff.operand & ~(8'h01 << s_ff.instruction_latch[7:5]);
         wr_file = 1'b1;
      end else if (s_ff.instruction_latch[11:8] == core_pkg::OPC_BIT_SET) begin
         res = s_ff.operand | (8'h01 << s_ff.instruction_latch[7:5]);
         wr_file = 1'b1;
      end else if (s_ff.instruction_latch[11:5] == core_pkg::OPC_MOVE_ACC_TO_FILE) begin
         res = s_ff.acc;
         wr_file = 1'b1;
      end else if (s_ff.instruction_latch[11:5] == core_pkg::OPC_FILE_CLEAR) begin
         res = 8'h00;
         wr_file = 1'b1;
         upd_zero = 1'b1;
      end else if (s_ff.instruction_latch[11:5] == core_pkg::OPC_CLEAR_ACC) begin
         res = 8'h00;
         wr_acc = 1'b1;
         upd_zero = 1'b1;
      end else if (s_ff.instruction_latch[11:6] == core_pkg::OPC_ADD) begin
         sum = {1'b0, s_ff.operand} + {1'b0, s_ff.acc};
         nibble_sum = {1'b0, s_ff.operand[3:0]} + {1'b0, s_ff.acc[3:0]};
         res = sum[7:0];
         upd_zero = 1'b1;
         upd_arith = 1'b1;
      end else if (s_ff.instruction_latch[11:6] == core_pkg::OPC_SUB) begin
         // Adding the complement plus one leaves carry set when no borrow occurred.
         sum = {1'b0, s_ff.operand} + {1'b0, ~s_ff.acc} + 9'h001;
         nibble_sum = {1'b0, s_ff.operand[3:0]} + {1'b0, ~s_ff.acc[3:0]} + 5'h01;
         res = sum[7:0];
         upd_zero = 1'b1;
         upd_arith = 1'b1;
      end else if (s_ff.instruction_latch[11:6] == core_pkg::OPC_AND) begin
         res = s_ff.operand & s_ff.acc;
         upd_zero = 1'b1;
      end else if (s_ff.instruction_latch[11:6] == core_pkg::OPC_IOR) begin
         res = s_ff.operand | s_ff.acc;
         upd_zero = 1'b1;
      end else if (s_ff.instruction_latch[11:6] == core_pkg::OPC_MOVE_FILE) begin
         res = s_ff.operand;
         upd_zero = 1'b1;
      end
      // Arithmetic forms pick accumulator or file by the destination bit.
      if (upd_arith || (upd_zero && s_ff.instruction_latch[11:6] != 6'h00 &&
                        !wr_acc && !wr_file)) begin
         wr_file = s_ff.instruction_latch[5];
         wr_acc = ~s_ff.instruction_latch[5];
      end
      // A write to the low counter byte changes the counter.
      if (wr_file && eff_addr == core_pkg::ADDR_PC_LOW) begin
         jump = 1'b1;
         jump_target = {2'b00, res} & pc_mask;
      end
   end

   // Next state of the whole core.
   always_comb begin
      nxt_s = s_ff;
      nxt_s.pin_meta = port_pin_in;
      nxt_s.pin_sync = s_ff.pin_meta;
      nxt_s.port_oe = ~s_ff.port_dir & 4'h7;
      if (restart != '0) begin
         // Every restart source puts the core back on the reset vector.
         nxt_s.pc = core_pkg::PC_RESET & pc_mask;
         nxt_s.instruction_latch = core_pkg::OPC_NOP;
         nxt_s.option = core_pkg::OPTION_RESET;
         nxt_s.port_dir = core_pkg::PORT_DIR_RESET;
         nxt_s.comparator = core_pkg::COMPARATOR_RESET;
         nxt_s.status[7:5] = 3'h0;
         if (restart.por) begin
            nxt_s.status = core_pkg::STATUS_POR;
            nxt_s.osc_trim = core_pkg::OSC_TRIM_RESET;
         end else if (restart.watchdog) begin
            nxt_s.status[core_pkg::ST_TIMEOUT] = 1'b0;
         end else if (restart.wake && !restart.ext_pin) begin
            nxt_s.status[core_pkg::ST_PIN_WAKE] = 1'b1;
            nxt_s.status[core_pkg::ST_POWERDOWN] = 1'b0;
         end
      end else begin
         case (phase)
            core_pkg::PH_ONE: begin
               // Fetch address leaves the counter, wrapped to the implemented depth.
               nxt_s.pc = pc_next;
               nxt_s.prog_addr = pc_next & depth_mask;
            end
            core_pkg::PH_TWO: begin
               nxt_s.operand = file_read(s_ff, eff_addr, gpr_index, gpr_valid);
            end
            core_pkg::PH_THREE: begin
               nxt_s.operand = s_ff.operand;
            end
            core_pkg::PH_FOUR: begin
               if (s_ff.instruction_latch == core_pkg::OPC_OPTION) begin
                  nxt_s.option = s_ff.acc;
               end else if (s_ff.instruction_latch == core_pkg::OPC_TRIS_PORT) begin
                  nxt_s.port_dir = s_ff.acc[3:0];
               end
               if (wr_acc) begin
                  nxt_s.acc = res;
               end
               // Destination write; address zero with pointer zero writes nothing.
               if (wr_file) begin
                  if (eff_addr == core_pkg::ADDR_INDIRECT) begin
                     nxt_s.timer0 = s_ff.timer0;
                  end else if (eff_addr == core_pkg::ADDR_TIMER0) begin
                     nxt_s.timer0 = res;
                  end else if (eff_addr == core_pkg::ADDR_STATUS) begin
                     nxt_s.status[7:5] = res[7:5];
                     if (!upd_zero) begin
                        nxt_s.status[core_pkg::ST_ZERO] = res[core_pkg::ST_ZERO];
                     end
                     // A file clear touches only the zero flag and the upper three bits.
                     if (!upd_arith &&
                         s_ff.instruction_latch[11:5] != core_pkg::OPC_FILE_CLEAR) begin
                        nxt_s.status[core_pkg::ST_DIGIT] = res[core_pkg::ST_DIGIT];
                        nxt_s.status[core_pkg::ST_CARRY] = res[core_pkg::ST_CARRY];
                     end
                  end else if (eff_addr == core_pkg::ADDR_POINTER) begin
                     nxt_s.pointer = res[4:0];
                  end else if (eff_addr == core_pkg::ADDR_OSC_TRIM) begin
                     nxt_s.osc_trim = res;
                  end else if (eff_addr == core_pkg::ADDR_PORT) begin
                     nxt_s.port_latch = res[3:0];
                  end else if (eff_addr == core_pkg::ADDR_COMPARATOR) begin
                     if (large_variant) begin
                        nxt_s.comparator = res;
                     end
                  end else if (gpr_valid) begin
                     nxt_s.general_purpose_register[gpr_index] = res;
                  end
               end
               // Flags follow the result, overriding any write to status.
               if (upd_zero) begin
                  nxt_s.status[core_pkg::ST_ZERO] = (res == 8'h00);
               end
               if (upd_arith) begin
                  nxt_s.status[core_pkg::ST_CARRY] = sum[8];
                  nxt_s.status[core_pkg::ST_DIGIT] = nibble_sum[4];
               end
               // The fetched word is latched, or dropped when the counter changed.
               // The counter holds the last fetched address, so it is left one short of
               // the target; the next phase one then fetches the target word itself.
               if (jump) begin
                  nxt_s.pc = (jump_target - 10'h001) & pc_mask;
                  nxt_s.instruction_latch = core_pkg::OPC_NOP;
               end else begin
                  nxt_s.instruction_latch = prog_data;
               end
            end
            default: begin
               nxt_s.operand = s_ff.operand;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_ff <= '{pc: core_pkg::PC_RESET, prog_addr: 10'h000,
                   instruction_latch: core_pkg::OPC_NOP, acc: 8'h00,
                   operand: 8'h00, status: core_pkg::STATUS_POR, pointer: 5'h00,
                   timer0: 8'h00, osc_trim: core_pkg::OSC_TRIM_RESET,
                   comparator: core_pkg::COMPARATOR_RESET, port_latch: 4'h0,
                   port_dir: core_pkg::PORT_DIR_RESET, port_oe: 4'h0,
                   option: core_pkg::OPTION_RESET, pin_meta: 4'h0, pin_sync: 4'h0,
                   general_purpose_register: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register.
   assign prog_addr = s_ff.prog_addr;
   assign port_pin_out = s_ff.port_latch;
   assign port_pin_oe = s_ff.port_oe;
   assign option_cfg = s_ff.option;
   assign acc_value = s_ff.acc;

endmodule // core_fetch_regfile

`default_nettype wire

// File: core_fetch_regfile_props.sv
/*
 Concurrent checks on the ports of core_fetch_regfile.
 Assumes the bind at the foot of this file attaches it to every instance.
*/
`timescale 1ns/1ps
`default_nettype none

module core_fetch_regfile_props #(
   parameter bit large_variant = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ext_reset_pin_n,
   input wire logic watchdog_expired,
   input wire logic pin_change_wake,
   input wire logic [11:0] prog_data,
   input wire logic [9:0] prog_addr,
   input wire logic [7:0] option_cfg,
   input wire logic [7:0] acc_value,
   input wire core_pkg::phase_t phase
);
   localparam logic [9:0] depth = large_variant ? core_pkg::DEPTH_MASK_LARGE
                                                : core_pkg::DEPTH_MASK_SMALL;
   logic [5:0] hist_ff;
   logic restart_near;

   // Remembers recent restart requests, so that phase checks skip the forced restart.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         hist_ff <= 6'h00;
      else
         hist_ff <= {hist_ff[4:0], watchdog_expired | pin_change_wake | ~ext_reset_pin_n};
   end
   assign restart_near = (|hist_ff) | watchdog_expired | pin_change_wake | ~ext_reset_pin_n;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // One instruction cycle of four phases, and a reset pin held long enough to restart.
   sequence cycle_s;
      phase == core_pkg::PH_ONE ##1 phase == core_pkg::PH_TWO ##1
      phase == core_pkg::PH_THREE ##1 phase == core_pkg::PH_FOUR;
   endsequence
   sequence pin_held_s;
      (!ext_reset_pin_n) [*6];
   endsequence

   phase_onehot_a: assert property ($onehot(phase))
      else $error("phase is not one-hot");
   phase_order_a: assert property (disable iff (rst || restart_near)
      phase == core_pkg::PH_ONE |-> cycle_s ##1 phase == core_pkg::PH_ONE)
      else $error("phase order broken");
   fetch_hold_a: assert property (disable iff (rst || restart_near)
      phase != core_pkg::PH_ONE |=> $stable(prog_addr))
      else $error("fetch address moved outside phase one");
   fetch_wrap_a: assert property ((prog_addr & ~depth) == 10'h000)
      else $error("fetch address beyond implemented memory");
   jump_cost_a: assert property (disable iff (rst || restart_near)
      (phase == core_pkg::PH_FOUR && prog_data[11:9] == 3'h5) |->
      ##6 prog_addr == ({1'b0, $past(prog_data[8:0], 6)} & depth))
      else $error("jump target not fetched after two cycles");
   acc_write_a: assert property (disable iff (rst || restart_near)
      phase != core_pkg::PH_FOUR |=> $stable(acc_value))
      else $error("accumulator written outside phase four");
   option_write_a: assert property (disable iff (rst || restart_near)
      phase != core_pkg::PH_FOUR |=> $stable(option_cfg))
      else $error("option written outside phase four");
   restart_option_a: assert property ((watchdog_expired || pin_change_wake)
      |-> ##[1:4] option_cfg == 8'hff)
      else $error("option not set by restart");
   restart_vector_a: assert property ($rose(watchdog_expired || pin_change_wake)
      |-> ##[2:12] (phase == core_pkg::PH_ONE) ##1 (prog_addr == 10'h000))
      else $error("restart did not fetch from zero");
   pin_restart_a: assert property (pin_held_s |->
      phase == core_pkg::PH_FOUR && option_cfg == 8'hff)
      else $error("reset pin did not hold the core");

endmodule // core_fetch_regfile_props

bind core_fetch_regfile core_fetch_regfile_props #(.large_variant(large_variant))
   u_core_fetch_regfile_props (.sys_clk(sys_clk), .rst(rst), .ext_reset_pin_n(ext_reset_pin_n),
   .watchdog_expired(watchdog_expired), .pin_change_wake(pin_change_wake),
   .prog_data(prog_data), .prog_addr(prog_addr), .option_cfg(option_cfg),
   .acc_value(acc_value), .phase(phase));

`default_nettype wire

// File: tb_core_fetch_regfile.sv
/*
 Self-checking bench for core_fetch_regfile, small variant.
 The bench plays program memory and drives the restart sources itself.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_core_fetch_regfile;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ext_reset_pin_n = 1'b1;
   logic watchdog_expired = 1'b0;
   logic pin_change_wake = 1'b0;
   logic [11:0] prog_data = 12'h000;
   logic [3:0] port_pin_in = 4'h3;
   logic [9:0] prog_addr;
   logic [3:0] port_pin_out;
   logic [3:0] port_pin_oe;
   logic [7:0] option_cfg;
   logic [7:0] acc_value;
   core_pkg::phase_t phase;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   // Program at the bottom of memory, jumping into the top sixteen words.
   logic [11:0] lo_words [0:7] = '{12'hc5a, 12'h002, 12'h030, 12'hc00, 12'h210, 12'h006,
                                   12'h026, 12'hbf0};
   logic [11:0] hi_words [0:15] = '{12'hc03, 12'h023, 12'h203, 12'h063, 12'h203, 12'hc11,
                                    12'h024, 12'hc77, 12'h020, 12'h206, 12'h211, 12'hc05,
                                    12'h032, 12'hc03, 12'h092, 12'h203};
   // Fetch address reached and the accumulator then expected.
   logic [9:0] chk_addr [0:8] = '{10'h002, 10'h006, 10'h0f2, 10'h0f4, 10'h0f6, 10'h0fb,
                                  10'h0fc, 10'h000, 10'h001};
   logic [7:0] chk_acc [0:8] = '{8'h5a, 8'h5a, 8'h03, 8'h1b, 8'h1f, 8'h03, 8'h77, 8'h02, 8'h1b};

   always #2 sys_clk = ~sys_clk;

   // Program memory answers the fetch address on the following edge; it is never written.
   always @(posedge sys_clk) begin
      prog_data <= (prog_addr[7:4] == 4'hf) ? hi_words[prog_addr[3:0]] :
                   (prog_addr < 10'h008) ? lo_words[prog_addr[2:0]] : 12'h000;
   end

   core_fetch_regfile #(.large_variant(1'b0)) u_core_fetch_regfile (
      .sys_clk(sys_clk),
      .rst(rst),
      .ext_reset_pin_n(ext_reset_pin_n),
      .watchdog_expired(watchdog_expired),
      .pin_change_wake(pin_change_wake),
      .prog_data(prog_data),
      .port_pin_in(port_pin_in),
      .prog_addr(prog_addr),
      .port_pin_out(port_pin_out),
      .port_pin_oe(port_pin_oe),
      .option_cfg(option_cfg),
      .acc_value(acc_value),
      .phase(phase)
   );

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Waits, within a bound, until the core fetches from the given address.
   task automatic wait_addr(input logic [9:0] a, input int lim);
      for (int n = 0; n < lim && prog_addr !== a; n++) begin
         @(posedge sys_clk);
         #1;
      end
   endtask

   task automatic end_of_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test();
      end
   end

   // Runs the program through the jump and the wrap, then the watchdog, wake and reset-pin restarts.
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      wait_addr(10'h000, 10);
      check("reset fetch address", 10'h000, prog_addr);
      check("option after reset", 10'h0ff, {2'h0, option_cfg});
      check("acc after reset", 10'h000, {2'h0, acc_value});
      for (int i = 0; i < 9; i++) begin
         wait_addr(chk_addr[i], 60);
         check("fetch address", chk_addr[i], prog_addr);
         check("accumulator", {2'h0, chk_acc[i]}, {2'h0, acc_value});
         if (i == 1)
            check("option", 10'h05a, {2'h0, option_cfg});
         if (i == 2) begin
            check("port enable", 10'h005, {6'h00, port_pin_oe});
            check("port output", 10'h00a, {6'h00, port_pin_out});
         end
      end
      for (int i = 0; i < 3; i++) begin
         for (int n = 0; n < 300 && option_cfg !== 8'h5a; n++) begin
            @(posedge sys_clk);
            #1;
         end
         @(posedge sys_clk);
         watchdog_expired <= (i == 0);
         pin_change_wake <= (i == 1);
         ext_reset_pin_n <= (i != 2);
         repeat (i == 2 ? 10 : 1) @(posedge sys_clk);
         watchdog_expired <= 1'b0;
         pin_change_wake <= 1'b0;
         ext_reset_pin_n <= 1'b1;
         wait_addr(10'h000, 30);
         check("restart fetch address", 10'h000, prog_addr);
         check("restart option", 10'h0ff, {2'h0, option_cfg});
      end
      end_of_test();
   end

endmodule // tb_core_fetch_regfile

`default_nettype wire
